// file: core/autoneg_ability_registers.sv
// auto-negotiation advertisement, partner ability and expansion registers
`timescale 1ns/1ps
// Notes on behaviour
// - bits 11:10 pause advertisement, reset none
// - resolved pause never both kinds at once
// - ability bits 8..5 writable, bit 7 resets high
// - bits 8,6,5 reset from sampled mode straps
// - selector 4:0 resets 00001, partner copy read-only
// - partner next-page bit 15 read-only; no local next-page
// - partner bit 14 set once code word received
// - partner bit 13 shows partner remote fault
// - partner bit 10 shows partner pause support
// - partner bit 9 shows partner T4 ability
// - partner bits 8..5 mirror partner abilities
// - expansion bit 4 latches parallel-detection fault
// - expansion bit 3 shows partner next-page ability
// - expansion bit 2 always reads zero
// - expansion bit 1 latches new page received
// - expansion bit 0 partner AN able; 15:5 zero
module autoneg_ability_registers
  import autoneg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire mgmt_req_t   req,
  input  wire logic [2:0]  mode_strap,
  input  wire line_in_t    line,
  output logic [15:0]      rdata,
  output logic             rvalid,
  output logic [15:0]      adv_word,
  output logic [1:0]       pause_res
);

  // ****************************************************************
  // state
  // ****************************************************************
  boot_t       boot_q;
  logic [15:0] adv_q;
  logic [15:0] lp_q;
  logic        pdf_q;
  logic        prx_q;
  logic        lpan_q;
  logic [15:0] rdata_q;
  logic        rvalid_q;
  logic [1:0]  pause_q;
  logic [15:0] exp_word;
  logic        adv_wr;
  logic        exp_rd;

  // strap code maps straight onto {100 full, 10 full, 10 half}
  function automatic logic [2:0] strap_abil(input logic [2:0] m);
    strap_abil = m;
  endfunction

  // request decode; a read and a write may share one cycle
  assign adv_wr = req.wr && (req.idx == ADV_IDX);
  assign exp_rd = req.rd && (req.idx == EXP_IDX);

  // ****************************************************************
  // strap capture
  // ****************************************************************
  // straps are caught on the first edge after release, not by the reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_q <= ST_STRAP;
    end else begin
      case (boot_q)
        ST_STRAP: boot_q <= ST_RUN;
        ST_RUN:   boot_q <= ST_RUN;
        default:  boot_q <= ST_STRAP;
      endcase
    end
  end

  // ****************************************************************
  // local advertisement
  // ****************************************************************
  // strap load overrides a write made in the same first cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adv_q <= ADV_RST;
    end else if (boot_q == ST_STRAP) begin
      {adv_q[TXFD_BIT], adv_q[TFD_BIT], adv_q[T_BIT]} <= strap_abil(mode_strap);
    end else if (adv_wr) begin
      adv_q <= req.wdata & ADV_WMASK;
    end
  end

  // ****************************************************************
  // partner ability capture
  // ****************************************************************
  // the partner's word is kept through LP_MASK, so bits 12:11 read zero; ack reflects receipt
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lp_q <= LP_RST;
    end else if (line.lp_clear) begin
      lp_q <= LP_RST;
    end else if (line.lp_word_vld) begin
      lp_q                     <= line.lp_word & LP_MASK;
      lp_q[ACK_BIT]            <= 1'b1;
    end
  end

  // ****************************************************************
  // expansion status
  // ****************************************************************
  // a read clears the latch, but a live condition wins over the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pdf_q <= 1'b0;
      prx_q <= 1'b0;
    end else begin
      pdf_q <= line.pd_fault || (pdf_q && !exp_rd);
      prx_q <= line.page_rx || (prx_q && !exp_rd);
    end
  end

  // partner auto-negotiation ability is a plain level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lpan_q <= 1'b0;
    end else begin
      lpan_q <= line.lp_an_able;
    end
  end

  // local next-page is fixed at zero, the rest reserved
  always_comb begin
    exp_word           = ZERO_WORD;
    exp_word[PDF_BIT]  = pdf_q;
    exp_word[LPNP_BIT] = lp_q[NP_BIT];
    exp_word[LNP_BIT]  = 1'b0;
    exp_word[PRX_BIT]  = prx_q;
    exp_word[LPAN_BIT] = lpan_q;
  end

  // ****************************************************************
  // management read path
  // ****************************************************************
  // indices outside this block read as zero here; another block answers them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q  <= ZERO_WORD;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd) begin
        case (req.idx)
          ADV_IDX: rdata_q <= adv_q;
          LP_IDX:  rdata_q <= lp_q;
          EXP_IDX: rdata_q <= exp_word;
          default: rdata_q <= ZERO_WORD;
        endcase
      end
    end
  end

  // ****************************************************************
  // pause resolution
  // ****************************************************************
  // partner shows one pause bit only, so symmetric is preferred
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pause_q <= PAUSE_NONE;
    end else if (!line.an_complete || !lp_q[PAUSE_LSB]) begin
      pause_q <= PAUSE_NONE;
    end else if (adv_q[PAUSE_LSB]) begin
      pause_q <= PAUSE_SYM;
    end else if (adv_q[PAUSE_LSB+1]) begin
      pause_q <= PAUSE_ASYM;
    end else begin
      pause_q <= PAUSE_NONE;
    end
  end

  // outputs are the registers themselves, no logic after them
  assign rdata     = rdata_q;
  assign rvalid    = rvalid_q;
  assign adv_word  = adv_q;
  assign pause_res = pause_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  adv_write_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (boot_q == ST_RUN && adv_wr) |=> (adv_q == ($past(req.wdata) & ADV_WMASK)))
    else $error("advertisement write not stored");

  adv_reserved_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    adv_wr |=> (adv_q[15:14] == 2'h0 && !adv_q[12] && !adv_q[9]))
    else $error("reserved advertisement bit set");

  strap_load_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (boot_q == ST_STRAP) |=> ({adv_q[TXFD_BIT], adv_q[TFD_BIT], adv_q[T_BIT]} == $past(mode_strap))
      ##1 (boot_q == ST_RUN))
    else $error("strap defaults not loaded");

  pause_single_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (pause_q != 2'h3) && ($past(line.an_complete) || pause_q == PAUSE_NONE))
    else $error("pause resolved to both kinds");

  ack_set_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (line.lp_word_vld && !line.lp_clear) |=> lp_q[ACK_BIT])
    else $error("code word receipt not flagged");

  lh_hold_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    line.pd_fault |=> pdf_q ##1 (pdf_q || $past(exp_rd)))
    else $error("parallel fault latch lost");

  lh_clear_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (exp_rd && !line.pd_fault && !line.page_rx) |=> (!pdf_q && !prx_q))
    else $error("latched bits not cleared by read");

  page_latch_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (line.page_rx ##1 (!exp_rd && !line.page_rx)) |=> prx_q)
    else $error("page received latch dropped");

  exp_read_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    exp_rd |=> (rvalid_q && !rdata_q[LNP_BIT] && rdata_q[15:5] == 11'h000))
    else $error("expansion read shows local next page");

  lp_ro_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (req.wr && req.idx == LP_IDX && !line.lp_word_vld && !line.lp_clear) |=> $stable(lp_q))
    else $error("partner register changed by write");

  // ****************************************************************
  // checks: local advertisement
  // ****************************************************************
  // what software writes to the ADV_WMASK bits is what the partner will be offered
  adv_fault_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (boot_q == ST_RUN && adv_wr) |=> (adv_q[RF_BIT] == $past(req.wdata[RF_BIT])))
    else $error("local fault flag not stored");

  pause_field_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (boot_q == ST_RUN && adv_wr) |=> (adv_q[PAUSE_LSB+1:PAUSE_LSB] == $past(req.wdata[PAUSE_LSB+1:PAUSE_LSB])))
    else $error("pause advertisement not stored");

  adv_hold_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (boot_q == ST_RUN && !adv_wr) |=> $stable(adv_q))
    else $error("advertisement changed without a write");

  adv_defaults_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (boot_q == ST_STRAP) |=> (adv_q[TX_BIT] && !adv_q[RF_BIT] && adv_q[SEL_LSB+4:SEL_LSB] == SEL_IEEE
      && adv_q[PAUSE_LSB+1:PAUSE_LSB] == PAUSE_NONE))
    else $error("fixed advertisement defaults lost");

  reserved_zero_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (adv_q & ~ADV_WMASK) == ZERO_WORD)
    else $error("reserved advertisement bit seen");

  // ****************************************************************
  // checks: partner register
  // ****************************************************************
  // each partner field is kept as the partner sent it, except bits 12:11, which read zero, and ack bit 14
  lp_np_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (line.lp_word_vld && !line.lp_clear) |=> (lp_q[NP_BIT] == $past(line.lp_word[NP_BIT])
      && lp_q[T4_BIT] == $past(line.lp_word[T4_BIT])))
    else $error("partner next page or T4 not captured");

  lp_fault_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (line.lp_word_vld && !line.lp_clear) |=> (lp_q[RF_BIT] == $past(line.lp_word[RF_BIT])))
    else $error("partner fault not captured");

  lp_pause_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (line.lp_word_vld && !line.lp_clear) |=> (lp_q[PAUSE_LSB] == $past(line.lp_word[PAUSE_LSB])
      && lp_q[PAUSE_LSB+2:PAUSE_LSB+1] == 2'h0))
    else $error("partner pause flag not captured");

  lp_abil_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (line.lp_word_vld && !line.lp_clear) |=> (lp_q[TXFD_BIT:T_BIT] == $past(line.lp_word[TXFD_BIT:T_BIT])))
    else $error("partner abilities not captured");

  lp_clear_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    line.lp_clear |=> (lp_q == LP_RST))
    else $error("partner register not cleared");

  lp_idle_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!line.lp_word_vld && !line.lp_clear) |=> $stable(lp_q))
    else $error("partner register changed with no capture");

  // ****************************************************************
  // checks: expansion and read path
  // ****************************************************************
  // a fault or page arriving in the reading cycle must survive the read
  pdf_set_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (line.pd_fault && exp_rd) |=> pdf_q)
    else $error("parallel fault lost to a read");

  prx_set_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (line.page_rx && exp_rd) |=> prx_q)
    else $error("page received lost to a read");

  lpnp_read_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    exp_rd |=> (rdata_q[LPNP_BIT] == $past(lp_q[NP_BIT])))
    else $error("partner next page ability misreported");

  lpan_level_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    1'b1 |=> (lpan_q == $past(line.lp_an_able)))
    else $error("partner negotiation ability not followed");

  adv_read_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (req.rd && req.idx == ADV_IDX) |=> (rvalid_q && rdata_q == $past(adv_q)))
    else $error("advertisement read wrong");

  lp_read_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (req.rd && req.idx == LP_IDX) |=> (rvalid_q && rdata_q == $past(lp_q)))
    else $error("partner read wrong");

  // ****************************************************************
  // checks: pause resolution
  // ****************************************************************
  // once negotiation completes, symmetric wins whenever both sides offer it
  pause_sym_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (line.an_complete && lp_q[PAUSE_LSB] && adv_q[PAUSE_LSB]) |=> (pause_q == PAUSE_SYM))
    else $error("symmetric pause not chosen");

  pause_asym_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (line.an_complete && lp_q[PAUSE_LSB] && !adv_q[PAUSE_LSB] && adv_q[PAUSE_LSB+1]) |=> (pause_q == PAUSE_ASYM))
    else $error("asymmetric pause not chosen");

endmodule

// file: core/autoneg_pkg.sv
// shared constants and carriers for the auto-negotiation ability registers
package autoneg_pkg;

  // ****************************************************************
  // register indices on the management port
  // ****************************************************************
  localparam logic [4:0]  ADV_IDX     = 5'h04;
  localparam logic [4:0]  LP_IDX      = 5'h05;
  localparam logic [4:0]  EXP_IDX     = 5'h06;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int          NP_BIT      = 15;
  localparam int          ACK_BIT     = 14;
  localparam int          RF_BIT      = 13;
  localparam int          PAUSE_LSB   = 10;
  localparam int          T4_BIT      = 9;
  localparam int          TXFD_BIT    = 8;
  localparam int          TX_BIT      = 7;
  localparam int          TFD_BIT     = 6;
  localparam int          T_BIT       = 5;
  localparam int          SEL_LSB     = 0;
  localparam int          PDF_BIT     = 4;
  localparam int          LPNP_BIT    = 3;
  localparam int          LNP_BIT     = 2;
  localparam int          PRX_BIT     = 1;
  localparam int          LPAN_BIT    = 0;

  // ****************************************************************
  // reset values, masks and encodings
  // ****************************************************************
  localparam logic [4:0]  SEL_IEEE    = 5'h01;
  localparam logic [15:0] ADV_RST     = 16'h0081;
  localparam logic [15:0] LP_RST      = 16'h0001;
  localparam logic [15:0] ADV_WMASK   = 16'h2DFF;
  localparam logic [15:0] LP_MASK     = 16'hA7FF;
  localparam logic [1:0]  PAUSE_NONE  = 2'h0;
  localparam logic [1:0]  PAUSE_SYM   = 2'h1;
  localparam logic [1:0]  PAUSE_ASYM  = 2'h2;
  localparam logic [15:0] ZERO_WORD   = 16'h0000;

  typedef enum logic {ST_STRAP, ST_RUN} boot_t;

  // management access, one request per cycle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  idx;
    logic [15:0] wdata;
  } mgmt_req_t;

  // status coming from the line-side arbitration
  typedef struct packed {
    logic [15:0] lp_word;
    logic        lp_word_vld;
    logic        lp_clear;
    logic        page_rx;
    logic        pd_fault;
    logic        lp_an_able;
    logic        an_complete;
  } line_in_t;

endpackage

// file: verif/mgmt_model.sv
// management controller model issuing register reads and writes
`timescale 1ns/1ps
module mgmt_model
  import autoneg_pkg::*;
(
  input  wire logic        clk,
  output mgmt_req_t        req,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid
);
  // idle until the first call
  initial req = '0;

  // one write, taken at the edge after it is raised
  // released index and data show the inverse, not a stale copy
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    @(posedge clk) #1;
    req.wr    = 1'b1;
    req.idx   = idx;
    req.wdata = d;
    @(posedge clk) #1;
    req.wr    = 1'b0;
    req.idx   = ~idx;
    req.wdata = ~d;
  endtask

  // one read; the answer stands for one cycle after the taking edge
  task automatic rd(input logic [4:0] idx, output logic [15:0] d, output logic ok);
    @(posedge clk) #1;
    req.rd  = 1'b1;
    req.idx = idx;
    @(posedge clk) #1;
    d       = rdata;
    ok      = rvalid;
    req.rd  = 1'b0;
    req.idx = ~idx;
  endtask
endmodule

// file: verif/tb.sv
// self-checking bench for the auto-negotiation ability registers
`timescale 1ns/1ps
module tb
  import autoneg_pkg::*;
;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [2:0]  mode_strap = 3'h5;
  line_in_t    line = '0;
  mgmt_req_t   req;
  logic [15:0] rdata;
  logic        rvalid;
  logic [15:0] adv_word;
  logic [1:0]  pause_res;
  int          failures = 0;
  int          n_compared = 0;

  // ************************************************************
  // clock, design and management model
  // ************************************************************
  always #20 clk = ~clk;

  autoneg_ability_registers uut (.clk(clk), .arst_n(arst_n), .req(req), .mode_strap(mode_strap),
    .line(line), .rdata(rdata), .rvalid(rvalid), .adv_word(adv_word), .pause_res(pause_res));

  mgmt_model m (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  // ************************************************************
  // compare helpers
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // a read must answer with rvalid as well as data
  task automatic rdchk(input logic [4:0] idx, input logic [15:0] exp, input string msg);
    logic [15:0] d;
    logic        ok;
    m.rd(idx, d, ok);
    chk({15'h0000, ok}, 16'h0001, "rvalid");
    chk(d, exp, msg);
  endtask

  // partner word capture pulse; released word shows its inverse
  task automatic cap(input logic [15:0] w);
    @(posedge clk) #1;
    line.lp_word     = w;
    line.lp_word_vld = 1'b1;
    @(posedge clk) #1;
    line.lp_word_vld = 1'b0;
    line.lp_word     = ~w;
  endtask

  task automatic final_report();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ************************************************************
  // watchdog: the tests need well under a thousand cycles
  // ************************************************************
  initial begin
    #200000;
    failures++;
    final_report();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    // straps 101 give 100 full and 10 half on top of the fixed 0x0081
    rdchk(ADV_IDX, 16'h01A1, "advert reset");
    rdchk(LP_IDX, 16'h0001, "partner reset");
    rdchk(EXP_IDX, 16'h0000, "expansion reset");
    rdchk(5'h07, 16'h0000, "unmapped read");
    $display("test reset values done");
    m.wr(ADV_IDX, 16'hFFFF);
    rdchk(ADV_IDX, 16'h2DFF, "advert all ones");
    chk(adv_word, 16'h2DFF, "adv_word");
    m.wr(LP_IDX, 16'hFFFF);
    m.wr(EXP_IDX, 16'hFFFF);
    rdchk(LP_IDX, 16'h0001, "partner not writable");
    $display("test writes done");
    line.lp_an_able = 1'b1;
    cap(16'hFFFE);
    rdchk(LP_IDX, 16'hE7FE, "partner full word");
    rdchk(EXP_IDX, 16'h0009, "partner next page");
    cap(16'h0000);
    rdchk(LP_IDX, 16'h4000, "code word seen");
    // a clear wins over a capture in the same cycle
    @(posedge clk) #1;
    line.lp_word     = 16'hFFFE;
    line.lp_word_vld = 1'b1;
    line.lp_clear    = 1'b1;
    @(posedge clk) #1;
    line.lp_word_vld = 1'b0;
    line.lp_clear    = 1'b0;
    rdchk(LP_IDX, 16'h0001, "partner cleared");
    $display("test partner capture done");
    // one-cycle pulses must be held until read
    @(posedge clk) #1;
    line.pd_fault = 1'b1;
    line.page_rx  = 1'b1;
    @(posedge clk) #1;
    line.pd_fault = 1'b0;
    line.page_rx  = 1'b0;
    repeat (3) @(posedge clk);
    rdchk(EXP_IDX, 16'h0013, "latched");
    rdchk(EXP_IDX, 16'h0001, "cleared by read");
    line.pd_fault = 1'b1;
    rdchk(EXP_IDX, 16'h0011, "fault live");
    line.pd_fault = 1'b0;
    rdchk(EXP_IDX, 16'h0011, "not cleared while live");
    rdchk(EXP_IDX, 16'h0001, "cleared");
    $display("test latches done");
    // both pause kinds advertised: one setting at most is chosen
    m.wr(ADV_IDX, 16'h0C01);
    line.an_complete = 1'b1;
    cap(16'h0400);
    repeat (2) @(posedge clk);
    #1 chk({14'h0000, pause_res}, {14'h0000, PAUSE_SYM}, "pause both");
    m.wr(ADV_IDX, 16'h0801);
    repeat (2) @(posedge clk);
    #1 chk({14'h0000, pause_res}, {14'h0000, PAUSE_ASYM}, "pause asym only");
    line.an_complete = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({14'h0000, pause_res}, {14'h0000, PAUSE_NONE}, "pause idle");
    line.an_complete = 1'b1;
    cap(16'h0000);
    repeat (2) @(posedge clk);
    #1 chk({14'h0000, pause_res}, {14'h0000, PAUSE_NONE}, "partner offers no pause");
    $display("test pause done");
    // second reset mid-run with other straps: only 10 full set
    mode_strap = 3'h2;
    arst_n     = 1'b0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    rdchk(ADV_IDX, 16'h00C1, "advert after second reset");
    rdchk(LP_IDX, 16'h0001, "partner after second reset");
    chk({14'h0000, pause_res}, {14'h0000, PAUSE_NONE}, "pause after second reset");
    $display("test second reset done");
    final_report();
  end
endmodule
